// >>> fbm_host.sv
// Purpose: Host controller driving a byte-wide flash through its pins.
// Assumes: Flash pins are synchronous to mclk; one request at a time.
// Notes:   Long operations complete when wsm_idle_flag returns high.
// Notes on behaviour
// - Byte write and erase go out as two writes, unless refused for a low program supply.
// - Reads drive chip select and output gate low, write strobe high.
// - Output gate and write strobe never low together.
// - Host writes array-read before returning array data after an op.
// - Host writes with write strobe low under chip select low.
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defines.svh"
module fbm_host (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // User request
  input  wire logic          req_valid,
  input  wire fbm_pkg::fbm_op_t req_op,
  input  wire logic [19:0]   req_addr,
  input  wire logic [7:0]    req_data,
  input  wire logic          req_alt_setup,
  input  wire logic          req_powerdown,
  input  wire logic          program_supply_high,
  output logic               req_ready,
  output logic               resp_valid,
  output logic [7:0]         resp_data,
  output logic               resp_error,
  // Flash pins
  output logic [19:0]        flash_addr,
  input  wire logic [7:0]    data_lines_in,
  output logic [7:0]         data_lines_out,
  output logic               data_lines_oe,
  output logic               chip_sel_n,
  output logic               out_gate_n,
  output logic               write_strobe_n,
  output logic               powerdown_reset_n,
  input  wire logic          wsm_idle_flag
);
  typedef enum logic [3:0] {
    FBM_S_DOWN, FBM_S_WAKE, FBM_S_IDLE, FBM_S_CMD, FBM_S_OPER,
    FBM_S_RDCYC, FBM_S_WAIT, FBM_S_RESTORE, FBM_S_DONE
  } fbm_state_t;

  fbm_state_t       st_q, st_d;
  fbm_pkg::fbm_op_t op_q, op_d;
  logic [19:0]      addr_q, addr_d;
  logic [7:0]       data_q, data_d, cmd_q, cmd_d, rd_q, rd_d;
  logic [3:0]       wake_q, wake_d;
  logic             array_mode_q, array_mode_d, err_q, err_d;
  logic             cyc_start, cyc_wr, cyc_done, strobe_low, writing;

  fbm_cycle u_cycle (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .start      (cyc_start),
    .is_write   (cyc_wr),
    .done       (cyc_done),
    .strobe_low (strobe_low),
    .writing    (writing)
  );

  function automatic logic [7:0] first_cmd(fbm_pkg::fbm_op_t op, logic alt);
    case (op)
      fbm_pkg::FBM_OP_READ:       first_cmd = `FBM_CMD_READ_ARRAY;
      fbm_pkg::FBM_OP_READ_ID:    first_cmd = `FBM_CMD_READ_ID;
      fbm_pkg::FBM_OP_READ_STAT:  first_cmd = `FBM_CMD_READ_STAT;
      fbm_pkg::FBM_OP_CLR_STAT:   first_cmd = `FBM_CMD_CLR_STAT;
      fbm_pkg::FBM_OP_ERASE:      first_cmd = `FBM_CMD_ERASE_SET;
      fbm_pkg::FBM_OP_SUSPEND:    first_cmd = `FBM_CMD_SUSPEND;
      fbm_pkg::FBM_OP_RESUME:     first_cmd = `FBM_CMD_CONFIRM;
      fbm_pkg::FBM_OP_WRITE_BYTE:
        first_cmd = alt ? `FBM_CMD_WRITE_ALT : `FBM_CMD_WRITE_SET;
      default:                    first_cmd = `FBM_CMD_READ_ARRAY;
    endcase
  endfunction

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    cmd_d = cmd_q;
    rd_d = rd_q;
    wake_d = wake_q;
    array_mode_d = array_mode_q;
    err_d = 1'b0;
    cyc_start = 1'b0;
    cyc_wr = 1'b0;
    resp_valid = 1'b0;
    req_ready = 1'b0;
    if (req_powerdown) begin
      st_d = FBM_S_DOWN;
    end else begin
      case (st_q)
        FBM_S_DOWN: begin
          wake_d = 4'(`FBM_WAKE_CYC);
          array_mode_d = 1'b1;
          st_d = FBM_S_WAKE;
        end
        FBM_S_WAKE: begin
          wake_d = wake_q - 4'h1;
          if (wake_q == 4'h1)
            st_d = FBM_S_IDLE;
        end
        FBM_S_IDLE: begin
          req_ready = 1'b1;
          if (req_valid) begin
            op_d = req_op;
            addr_d = req_addr;
            data_d = req_data;
            cmd_d = first_cmd(req_op, req_alt_setup);
            if (req_op == fbm_pkg::FBM_OP_READ_ID)
              addr_d = req_addr[0] ? `FBM_ID_PART_ADDR
                                   : `FBM_ID_MAKER_ADDR;
            if ((req_op == fbm_pkg::FBM_OP_ERASE ||
                 req_op == fbm_pkg::FBM_OP_WRITE_BYTE) &&
                !program_supply_high) begin
              err_d = 1'b1;
              st_d = FBM_S_DONE;
            end else if (req_op == fbm_pkg::FBM_OP_READ && array_mode_q) begin
              st_d = FBM_S_RDCYC;
            end else begin
              st_d = FBM_S_CMD;
            end
          end
        end
        FBM_S_CMD: begin
          cyc_start = 1'b1;
          cyc_wr = 1'b1;
          if (cyc_done) begin
            cyc_start = 1'b0;
            array_mode_d = (op_q == fbm_pkg::FBM_OP_READ);
            case (op_q)
              fbm_pkg::FBM_OP_ERASE: begin
                cmd_d = `FBM_CMD_CONFIRM;
                addr_d = {addr_q[19:16], 16'h0000};
                st_d = FBM_S_OPER;
              end
              fbm_pkg::FBM_OP_WRITE_BYTE: begin
                cmd_d = data_q;
                st_d = FBM_S_OPER;
              end
              fbm_pkg::FBM_OP_CLR_STAT,
              fbm_pkg::FBM_OP_SUSPEND: st_d = FBM_S_DONE;
              fbm_pkg::FBM_OP_RESUME: st_d = FBM_S_WAIT;
              default: st_d = FBM_S_RDCYC;
            endcase
          end
        end
        FBM_S_OPER: begin
          cyc_start = 1'b1;
          cyc_wr = 1'b1;
          if (cyc_done) begin
            cyc_start = 1'b0;
            st_d = FBM_S_WAIT;
          end
        end
        FBM_S_WAIT: begin
          // The flag falls an edge after the last strobe rises, so it is
          // ignored for a short settle time rather than read as done.
          if (wake_q != 4'h0)
            wake_d = wake_q - 4'h1;
          else if (wsm_idle_flag && !strobe_low) begin
            cmd_d = `FBM_CMD_READ_ARRAY;
            st_d = FBM_S_RESTORE;
          end
        end
        FBM_S_RESTORE: begin
          cyc_start = 1'b1;
          cyc_wr = 1'b1;
          if (cyc_done) begin
            cyc_start = 1'b0;
            array_mode_d = 1'b1;
            st_d = FBM_S_DONE;
          end
        end
        FBM_S_RDCYC: begin
          cyc_start = 1'b1;
          if (cyc_done) begin
            cyc_start = 1'b0;
            rd_d = data_lines_in;
            st_d = FBM_S_DONE;
          end
        end
        FBM_S_DONE: begin
          resp_valid = 1'b1;
          st_d = FBM_S_IDLE;
        end
        default: st_d = FBM_S_DOWN;
      endcase
    end
    if (st_q != FBM_S_IDLE)
      err_d = (st_q == FBM_S_DONE) ? 1'b0 : err_q;
    if (st_d == FBM_S_WAIT && st_q != FBM_S_WAIT)
      wake_d = 4'(`FBM_SETTLE_CYC);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= FBM_S_DOWN;
      op_q <= fbm_pkg::FBM_OP_READ;
      addr_q <= '0;
      data_q <= '0;
      cmd_q <= '0;
      rd_q <= '0;
      wake_q <= '0;
      array_mode_q <= 1'b1;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      cmd_q <= cmd_d;
      rd_q <= rd_d;
      wake_q <= wake_d;
      array_mode_q <= array_mode_d;
      err_q <= err_d;
    end
  end

  // Strobes come straight from the cycle timer, so at most one is low.
  assign powerdown_reset_n = (st_q != FBM_S_DOWN);
  assign chip_sel_n     = !strobe_low;
  assign write_strobe_n = !(strobe_low && writing);
  assign out_gate_n     = !(strobe_low && !writing);
  assign data_lines_oe  = strobe_low && writing;
  assign data_lines_out = cmd_q;
  assign flash_addr     = addr_q;
  assign resp_data      = rd_q;
  assign resp_error     = err_q;

  property p_no_overlap;
    @(posedge mclk) disable iff (!rst_n) !(!out_gate_n && !write_strobe_n);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("Output gate and write strobe low together.");

  property p_og_needs_cs;
    @(posedge mclk) disable iff (!rst_n) !out_gate_n |-> !chip_sel_n;
  endproperty
  a_og_needs_cs: assert property (p_og_needs_cs)
    else $error("Read strobe without chip select.");

  property p_no_drive_on_read;
    @(posedge mclk) disable iff (!rst_n) !out_gate_n |-> !data_lines_oe;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read)
    else $error("Host drives data during a read.");

  property p_refuse_low_supply;
    @(posedge mclk) disable iff (!rst_n)
      (st_q == FBM_S_IDLE && req_valid && !req_powerdown &&
       !program_supply_high && req_op == fbm_pkg::FBM_OP_ERASE)
      |=> st_q == FBM_S_DONE ##1 !resp_valid ##0 resp_error == 1'b0;
  endproperty
  a_refuse_low_supply: assert property (p_refuse_low_supply)
    else $error("Erase issued with program supply low.");

  property p_powerdown;
    @(posedge mclk) disable iff (!rst_n) req_powerdown |=> !powerdown_reset_n;
  endproperty
  a_powerdown: assert property (p_powerdown)
    else $error("Powerdown request not honoured.");

  property p_write_under_cs;
    @(posedge mclk) disable iff (!rst_n) !write_strobe_n |-> !chip_sel_n;
  endproperty
  a_write_under_cs: assert property (p_write_under_cs)
    else $error("Write strobe without chip select.");

  sequence s_wait_busy;
    st_q == FBM_S_WAIT && !wsm_idle_flag;
  endsequence
  property p_wait_holds;
    @(posedge mclk) disable iff (!rst_n)
      (s_wait_busy and !req_powerdown) |=> st_q == FBM_S_WAIT;
  endproperty
  a_wait_holds: assert property (p_wait_holds)
    else $error("Host left wait while flash busy.");

  property p_restore_read;
    @(posedge mclk) disable iff (!rst_n)
      st_q == FBM_S_RESTORE && !write_strobe_n |->
      data_lines_out == `FBM_CMD_READ_ARRAY;
  endproperty
  a_restore_read: assert property (p_restore_read)
    else $error("Restore write is not array read.");
endmodule
`default_nettype wire

// >>> fbm_defines.svh
// Purpose: Constants for the flash bus host controller.
// Assumes: 10 MHz mclk, byte-wide flash with 20 address lines.
// Notes:   Timing counts derive from times in nanoseconds.
`ifndef FBM_DEFINES_SVH
`define FBM_DEFINES_SVH
`define FBM_CLK_NS        100
`define FBM_CMD_READ_ARRAY 8'hFF
`define FBM_CMD_READ_ID    8'h90
`define FBM_CMD_READ_STAT  8'h70
`define FBM_CMD_CLR_STAT   8'h50
`define FBM_CMD_ERASE_SET  8'h20
`define FBM_CMD_CONFIRM    8'hD0
`define FBM_CMD_SUSPEND    8'hB0
`define FBM_CMD_WRITE_SET  8'h40
`define FBM_CMD_WRITE_ALT  8'h10
`define FBM_ID_MAKER_ADDR  20'h00000
`define FBM_ID_PART_ADDR   20'h00001
`define FBM_WAKE_NS        1000
`define FBM_WAKE_CYC       ((`FBM_WAKE_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_STROBE_NS      300
`define FBM_STROBE_CYC     ((`FBM_STROBE_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_SETTLE_NS      200
`define FBM_SETTLE_CYC     ((`FBM_SETTLE_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_CNT_W          4
`endif

// >>> fbm_pkg.sv
// Purpose: Types for the flash bus host controller.
// Assumes: Used with fbm_defines.svh.
// Notes:   Operation codes requested by the user side.
package fbm_pkg;
  typedef enum logic [2:0] {
    FBM_OP_READ,
    FBM_OP_READ_ID,
    FBM_OP_READ_STAT,
    FBM_OP_CLR_STAT,
    FBM_OP_WRITE_BYTE,
    FBM_OP_ERASE,
    FBM_OP_SUSPEND,
    FBM_OP_RESUME
  } fbm_op_t;
endpackage

// >>> fbm_cycle.sv
// Purpose: One bus cycle (read or write) on the flash pins.
// Assumes: Strobe low time is fixed in clock cycles.
// Notes:   Address and data are held while the strobe is low; they may change on the edge where it rises.
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defines.svh"
module fbm_cycle (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        start,
  input  wire logic        is_write,
  output logic             done,
  // Strobes
  output logic             strobe_low,
  output logic             writing
);
  logic [`FBM_CNT_W-1:0] cnt_q, cnt_d;
  logic                  busy_q, busy_d, wr_q, wr_d;

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    wr_d   = wr_q;
    done   = 1'b0;
    if (!busy_q && start) begin
      busy_d = 1'b1;
      wr_d   = is_write;
      cnt_d  = `FBM_CNT_W'(`FBM_STROBE_CYC);
    end else if (busy_q) begin
      if (cnt_q == `FBM_CNT_W'(1)) begin
        busy_d = 1'b0;
        done   = 1'b1;
      end
      cnt_d = cnt_q - `FBM_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      wr_q   <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      wr_q   <= wr_d;
    end
  end

  assign strobe_low = busy_q;
  assign writing    = wr_q;
endmodule
`default_nettype wire

// >>> fbm_flash_model.sv
// Purpose: Behavioural flash device facing the host controller.
// Assumes: Pins are sampled on mclk; writes act on the edge after the strobe rises.
// Notes:   Undriven data lines toggle, so a missed drive never reads right.
`timescale 1ns/1ps
`default_nettype none
module fbm_flash_model #(
  parameter int         BUSY_CYC = 20,
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value.
  parameter logic [7:0] PART_ID  = 8'h3C  // Arbitrary value.
) (
  // Clock and supply
  input  wire logic        mclk,
  input  wire logic        vpp_high,
  // Bus pins
  input  wire logic [19:0] flash_addr,
  input  wire logic [7:0]  dq_in,
  input  wire logic        dq_in_oe,
  input  wire logic        chip_sel_n,
  input  wire logic        out_gate_n,
  input  wire logic        write_strobe_n,
  input  wire logic        powerdown_reset_n,
  output logic [7:0]       dq_out,
  output logic             wsm_idle_flag
);
  typedef enum logic [1:0] {FBM_FM_ARRAY, FBM_FM_ID, FBM_FM_STAT} fbm_fm_t;
  logic [7:0]  mem [0:1048575];
  fbm_fm_t     mode = FBM_FM_ARRAY;
  logic [7:0]  setup_q = 8'h00;
  logic [19:0] lat_a = 20'h00000;
  logic [7:0]  lat_d = 8'h00;
  logic        we_q = 1'b1;
  logic [7:0]  last_q = 8'h00;
  int          busy = 0;
  logic        drive;

  initial for (int i = 0; i < 1048576; i++) mem[i] = ~i[7:0];

  assign wsm_idle_flag = (busy == 0);
  assign drive = powerdown_reset_n && !chip_sel_n && !out_gate_n;
  always_comb begin
    if (!drive) dq_out = ~last_q;
    else if (mode == FBM_FM_ID) dq_out = flash_addr[0] ? PART_ID : MAKER_ID;
    else if (mode == FBM_FM_STAT) dq_out = {wsm_idle_flag, 7'h00};
    else dq_out = mem[flash_addr];
  end

  always @(posedge mclk) begin
    last_q <= dq_out;
    we_q   <= write_strobe_n;
    if (!powerdown_reset_n) begin
      mode    <= FBM_FM_ARRAY;
      setup_q <= 8'h00;
      busy    <= 0;
    end else begin
      // The count runs on whatever chip select does.
      if (busy > 0) busy <= busy - 1;
      if (!write_strobe_n && !chip_sel_n) begin
        lat_a <= flash_addr;
        lat_d <= dq_in_oe ? dq_in : 8'hXX;
      end
      if (write_strobe_n && !we_q && busy == 0) begin
        setup_q <= 8'h00;
        if (setup_q == 8'h20) begin
          mode <= FBM_FM_STAT;
          if (lat_d == 8'hD0 && vpp_high) begin
            for (int k = 0; k < 65536; k++) mem[{lat_a[19:16], k[15:0]}] <= 8'hFF;
            busy <= BUSY_CYC;
          end
        end else if (setup_q != 8'h00) begin
          mode <= FBM_FM_STAT;
          if (vpp_high) begin
            mem[lat_a] <= mem[lat_a] & lat_d;
            busy <= BUSY_CYC;
          end
        end else case (lat_d)
          8'hFF: mode <= FBM_FM_ARRAY;
          8'h90: mode <= FBM_FM_ID;
          8'h70: mode <= FBM_FM_STAT;
          8'h20, 8'h40, 8'h10: setup_q <= lat_d;
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> fbm_host_tb.sv
// Purpose: Self-checking bench for the flash host controller.
// Assumes: The flash model fills byte i of the array with its inverted low byte.
// Notes:   A global cycle ceiling bounds every wait.
`timescale 1ns/1ps
`default_nettype none
module fbm_host_tb;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
  localparam logic [7:0] PART  = 8'h3C; // Arbitrary value.
  logic             mclk = 1'b0;
  logic             rst_n = 1'b0;
  logic             req_valid = 1'b0;
  logic             req_alt_setup = 1'b0;
  logic             req_powerdown = 1'b0;
  logic             vpp = 1'b1;
  fbm_pkg::fbm_op_t req_op = fbm_pkg::FBM_OP_READ;
  logic [19:0]      req_addr = 20'h00000;
  logic [7:0]       req_data = 8'h00;
  logic             req_ready, resp_valid, resp_error, data_lines_oe, er;
  logic             chip_sel_n, out_gate_n, write_strobe_n, powerdown_reset_n;
  logic             wsm_idle_flag;
  logic             saw_busy = 1'b0;
  logic [7:0]       resp_data, data_lines_out, data_lines_in, rd;
  logic [19:0]      flash_addr;
  int               n_errors = 0;
  int               checked = 0;
  int               cycles = 0;

  always #50 mclk = ~mclk;

  fbm_host dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .req_alt_setup(req_alt_setup), .req_powerdown(req_powerdown),
    .program_supply_high(vpp), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_error(resp_error),
    .flash_addr(flash_addr), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .write_strobe_n(write_strobe_n), .powerdown_reset_n(powerdown_reset_n),
    .wsm_idle_flag(wsm_idle_flag));

  fbm_flash_model #(.BUSY_CYC(20), .MAKER_ID(MAKER), .PART_ID(PART)) flash (
    .mclk(mclk), .vpp_high(vpp), .flash_addr(flash_addr),
    .dq_in(data_lines_out), .dq_in_oe(data_lines_oe),
    .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .write_strobe_n(write_strobe_n), .powerdown_reset_n(powerdown_reset_n),
    .dq_out(data_lines_in), .wsm_idle_flag(wsm_idle_flag));

  task automatic fail(input string msg);
    n_errors++;
    $display("unexpected at %0t ns: %s", $time, msg);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) fail(msg);
  endtask

  task automatic end_of_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  // Pins are checked mid-cycle, clear of the edge's own updates.
  always @(negedge mclk) begin
    cycles++;
    if (!wsm_idle_flag) saw_busy = 1'b1;
    if (!out_gate_n && !write_strobe_n) fail("gate and strobe both low");
    if (data_lines_oe && !out_gate_n) fail("host drives during a read");
    if (cycles == 20000) begin
      fail("timeout");
      end_of_test();
    end
  end

  task automatic do_req(input fbm_pkg::fbm_op_t op, input logic [19:0] a,
                        input logic [7:0] d, input logic alt);
    req_op = op;
    req_addr = a;
    req_data = d;
    req_alt_setup = alt;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) tick();
    tick();
    req_valid = 1'b0;
    while (resp_valid !== 1'b1) tick();
    rd = resp_data;
    er = resp_error;
    tick();
  endtask

  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
    do_req(fbm_pkg::FBM_OP_READ, a, 8'h00, 1'b0);
    chk(rd, exp, "array byte");
  endtask

  task automatic t_ident();
    vpp = 1'b0;
    do_req(fbm_pkg::FBM_OP_READ_ID, 20'h00000, 8'h00, 1'b0);
    chk(rd, MAKER, "maker code");
    do_req(fbm_pkg::FBM_OP_READ_ID, 20'h00001, 8'h00, 1'b0);
    chk(rd, PART, "part code");
    do_req(fbm_pkg::FBM_OP_READ_STAT, 20'h00000, 8'h00, 1'b0);
    chk(rd, 8'h80, "status idle");
  endtask

  task automatic t_refuse();
    do_req(fbm_pkg::FBM_OP_WRITE_BYTE, 20'h20020, 8'h00, 1'b0);
    chk({7'h00, er}, 8'h01, "write taken on low supply");
    do_req(fbm_pkg::FBM_OP_ERASE, 20'h20000, 8'h00, 1'b0);
    chk({7'h00, er}, 8'h01, "erase taken on low supply");
    vpp = 1'b1;
    rd_chk(20'h20020, 8'hDF);
  endtask

  task automatic t_erase_write();
    saw_busy = 1'b0;
    do_req(fbm_pkg::FBM_OP_ERASE, 20'h31234, 8'h00, 1'b0);
    chk({7'h00, er, saw_busy}, 8'h01, "erase result or busy");
    rd_chk(20'h30010, 8'hFF);
    rd_chk(20'h2FFFF, 8'h00);
    rd_chk(20'h40001, 8'hFE);
    do_req(fbm_pkg::FBM_OP_WRITE_BYTE, 20'h30010, 8'hA5, 1'b0);
    chk({7'h00, er}, 8'h00, "write refused");
    do_req(fbm_pkg::FBM_OP_WRITE_BYTE, 20'h30011, 8'h0F, 1'b1);
    rd_chk(20'h30010, 8'hA5);
    rd_chk(20'h30011, 8'h0F);
  endtask

  task automatic t_misc();
    fbm_pkg::fbm_op_t ops [3];
    ops = '{fbm_pkg::FBM_OP_CLR_STAT, fbm_pkg::FBM_OP_SUSPEND,
            fbm_pkg::FBM_OP_RESUME};
    foreach (ops[i]) begin
      do_req(ops[i], 20'h00000, 8'h00, 1'b0);
      chk({7'h00, er}, 8'h00, "command refused");
    end
    rd_chk(20'h00042, 8'hBD);
  endtask

  task automatic t_powerdown();
    do_req(fbm_pkg::FBM_OP_READ_ID, 20'h00000, 8'h00, 1'b0);
    req_powerdown = 1'b1;
    while (powerdown_reset_n !== 1'b0) tick();
    chk({6'h00, chip_sel_n, wsm_idle_flag}, 8'h03, "powerdown pins");
    tick();
    req_powerdown = 1'b0;
    rd_chk(20'h00001, 8'hFE);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd_chk(20'h00042, 8'hBD);
    t_ident();
    t_refuse();
    t_erase_write();
    t_misc();
    t_powerdown();
    end_of_test();
  end
endmodule
`default_nettype wire
